// ==== logic/cdt_pkg.sv ====
// Package: register map, field positions and bus carriers of the dual timer
package cdt_pkg;

  // Register word indices, address bits 13:2 (printed offsets are not all multiples of four)
  localparam logic [11:0] IDX_LOW_COUNT = 12'h106;
  localparam logic [11:0] IDX_HOLD = 12'h108;
  localparam logic [11:0] IDX_HIGH_COUNT = 12'h10a;
  localparam logic [11:0] IDX_PERIOD_LOW = 12'h10c;
  localparam logic [11:0] IDX_PERIOD_HIGH = 12'h10e;
  localparam logic [11:0] IDX_LOW_CTRL = 12'h110;
  localparam logic [11:0] IDX_HIGH_CTRL = 12'h112;
  localparam logic [11:0] IDX_IRQ_STATUS = 12'h114;
  localparam logic [11:0] IDX_IRQ_ENABLE = 12'h115;
  localparam int ADDR_W = 14;

  // Control field positions
  localparam int BIT_RUN = 15;
  localparam int BIT_STOP_IDLE = 13;
  localparam int BIT_GATE_EN = 6;
  localparam int BIT_PS_HI = 5;
  localparam int BIT_PS_LO = 4;
  localparam int BIT_CASCADE = 3;
  localparam int BIT_CLK_SRC = 1;
  localparam logic [15:0] LOW_CTRL_MASK = 16'ha07a;
  localparam logic [15:0] HIGH_CTRL_MASK = 16'ha072;

  // Interrupt flag positions (low timer bit 0, high timer bit 7)
  localparam int BIT_IRQ_LOW = 0;
  localparam int BIT_IRQ_HIGH = 7;

  // Reset values
  localparam logic [15:0] RST_PERIOD = 16'hffff;
  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic [15:0] RST_COUNT = 16'h0000;

  // Prescale terminal counts for 1:1, 1:8, 1:64, 1:256
  localparam logic [7:0] PS_DIV1 = 8'h00;
  localparam logic [7:0] PS_DIV8 = 8'h07;
  localparam logic [7:0] PS_DIV64 = 8'h3f;
  localparam logic [7:0] PS_DIV256 = 8'hff;

  // Bus request carrier
  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } cdt_req_s;

  // Bus answer carrier
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } cdt_rsp_s;

  // Bus slave phase
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_DONE = 1'b1
  } cdt_bus_e;

endpackage

// ==== logic/cdt_timer.sv ====
// Cascadable dual 16-bit / single 32-bit timer with Avalon-MM slave
//
// Overview of operation
// - Cascaded: low timer is lower 16 bits, high timer upper 16 bits.
// - Cascaded: high control ignored; low control, clock and gate used; clearing high run still clears low prescaler.
// - Cascaded: interrupts use high timer flag and high timer enable.
// - Split: two independent 16-bit timers or sync counters, no async mode; low count write also loads high count.
// - Low timer synchronises its prescaler output; high timer does not.
// - 32-bit timer counts instruction cycles to period, then wraps to zero.
// - Reading low count latches high count into holding register.
// - Write holding then low count; holding moves into high count.
// - 32-bit counter counts synchronised external rising edges to period.
// - In idle, stop-in-idle set halts counting; resumes when idle ends.
// - Gated mode counts cycles while gate high; needs enable, run, internal.
// - Gate enable ignored on high timer; low timer drives gated cascade.
// - Gate falling edge ends accumulation, count kept unchanged.
// - 32-bit period match pulses the converter trigger.
// - Prescaler divides by 1, 8, 64 or 256 from field bits 5:4.
// - Cascaded: only low timer prescaler applies.
// - Prescaler cleared on count write, run clear, or reset.
// - Low prescaler cannot reset while its timer is disabled.
// - Control writes leave count registers unchanged.
// - During sleep nothing counts.
// - 32-bit match or gate fall sets high flag; software clears it.
// - 16-bit timer counts cycles to its own period, then wraps.
// - Clock-source bit 1 selects pin clock, 0 instruction clock.
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/100ps

module cdt_timer (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // Register bus
  input wire cdt_pkg::cdt_req_s i_bus,
  output cdt_pkg::cdt_rsp_s o_bus,
  // Pins and processor power state
  input wire logic i_low_clk_pin,
  input wire logic i_high_clk_pin,
  input wire logic i_idle,
  input wire logic i_sleep,
  // Events
  output logic o_irq,
  output logic o_adc_trigger
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detect

  logic [1:0] pin_meta_ff;
  logic [1:0] pin_sync_ff;
  logic [1:0] pin_prev_ff;
  logic idle_meta_ff;
  logic idle_sync_ff;
  logic sleep_meta_ff;
  logic sleep_sync_ff;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      pin_meta_ff <= 2'h0;
      pin_sync_ff <= 2'h0;
      pin_prev_ff <= 2'h0;
      idle_meta_ff <= 1'b0;
      idle_sync_ff <= 1'b0;
      sleep_meta_ff <= 1'b0;
      sleep_sync_ff <= 1'b0;
    end else if (i_ce) begin
      pin_meta_ff <= {i_high_clk_pin, i_low_clk_pin};
      pin_sync_ff <= pin_meta_ff;
      pin_prev_ff <= pin_sync_ff;
      idle_meta_ff <= i_idle;
      idle_sync_ff <= idle_meta_ff;
      sleep_meta_ff <= i_sleep;
      sleep_sync_ff <= sleep_meta_ff;
    end
  end

  wire [1:0] pin_rise = pin_sync_ff & ~pin_prev_ff;
  wire [1:0] pin_fall = ~pin_sync_ff & pin_prev_ff;

  ////////////////////////////////////////////////////////////////////////
  // Registers and bus decode

  logic [15:0] count_ff [2];
  logic [15:0] period_ff [2];
  logic [15:0] ctrl_ff [2];
  logic [15:0] hold_ff;
  logic [7:0] irq_flag_ff;
  logic [7:0] irq_en_ff;
  cdt_pkg::cdt_bus_e bus_st_ff;
  logic [31:0] rdata_ff;
  logic irq_ff;
  logic adc_ff;

  wire [11:0] reg_idx = i_bus.address[13:2];
  wire bus_go = (bus_st_ff == cdt_pkg::ST_IDLE) && i_ce;
  // Writes land at the edge where the master sees waitrequest low
  wire wr_go = (bus_st_ff == cdt_pkg::ST_DONE) && i_ce && i_bus.write;
  wire rd_go = bus_go && i_bus.read;
  wire wr_low_cnt = wr_go && (reg_idx == cdt_pkg::IDX_LOW_COUNT);
  wire wr_high_cnt = wr_go && (reg_idx == cdt_pkg::IDX_HIGH_COUNT);
  wire wr_hold = wr_go && (reg_idx == cdt_pkg::IDX_HOLD);
  wire wr_per_low = wr_go && (reg_idx == cdt_pkg::IDX_PERIOD_LOW);
  wire wr_per_high = wr_go && (reg_idx == cdt_pkg::IDX_PERIOD_HIGH);
  wire wr_ctl_low = wr_go && (reg_idx == cdt_pkg::IDX_LOW_CTRL);
  wire wr_ctl_high = wr_go && (reg_idx == cdt_pkg::IDX_HIGH_CTRL);
  wire wr_irq_st = wr_go && (reg_idx == cdt_pkg::IDX_IRQ_STATUS);
  wire wr_irq_en = wr_go && (reg_idx == cdt_pkg::IDX_IRQ_ENABLE);
  wire rd_low_cnt = rd_go && (reg_idx == cdt_pkg::IDX_LOW_COUNT);
  wire [15:0] wdata = i_bus.writedata[15:0];
  wire lanes_ok = i_bus.byteenable[1:0] == 2'h3;

  wire cascade = ctrl_ff[0][cdt_pkg::BIT_CASCADE];

  ////////////////////////////////////////////////////////////////////////
  // Per-timer control selection, prescaler and increment

  // Effective control: cascaded mode uses low control for both halves
  logic [15:0] eff_ctrl [2];
  logic [7:0] ps_cnt_ff [2];
  logic tick_sync_ff;
  logic [1:0] tick;
  logic [1:0] ps_hit;
  logic [1:0] run_clear;
  logic [1:0] ps_clr;
  logic [1:0] match;
  logic [1:0] gate_fall;

  wire halt = sleep_sync_ff;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_tmr
      logic [15:0] c;
      logic [7:0] term;
      logic src_edge;
      logic active;
      logic gated;

      assign c = (g == 1 && cascade) ? ctrl_ff[0] : ctrl_ff[g];
      assign eff_ctrl[g] = c;

      assign term = (c[5:4] == 2'h0) ? cdt_pkg::PS_DIV1 :
                    (c[5:4] == 2'h1) ? cdt_pkg::PS_DIV8 :
                    (c[5:4] == 2'h2) ? cdt_pkg::PS_DIV64 :
                    cdt_pkg::PS_DIV256;

      // Gate enable only honoured on the low timer
      assign gated = (g == 0) && c[cdt_pkg::BIT_GATE_EN] &&
                     !c[cdt_pkg::BIT_CLK_SRC];

      // Stop in idle; stop in sleep
      assign active = c[cdt_pkg::BIT_RUN] && !halt &&
                      !(idle_sync_ff && c[cdt_pkg::BIT_STOP_IDLE]);

      // Source select; gate level qualifies cycles
      assign src_edge = c[cdt_pkg::BIT_CLK_SRC] ? pin_rise[g] :
                        (gated ? pin_sync_ff[g] : 1'b1);

      assign ps_hit[g] = active && src_edge && (ps_cnt_ff[g] == term);

      assign run_clear[g] = wr_ctl_low && lanes_ok &&
                            ctrl_ff[0][cdt_pkg::BIT_RUN] &&
                            !wdata[cdt_pkg::BIT_RUN] ||
                            wr_ctl_high && lanes_ok &&
                            ctrl_ff[1][cdt_pkg::BIT_RUN] &&
                            !wdata[cdt_pkg::BIT_RUN];
      // Low prescaler frozen while its timer is off
      assign ps_clr[g] = (wr_low_cnt || wr_high_cnt || run_clear[g]) &&
                         !(g == 0 && !ctrl_ff[0][cdt_pkg::BIT_RUN]);

      always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
          ps_cnt_ff[g] <= 8'h00;
        end else if (i_ce) begin
          if (ps_clr[g]) begin
            ps_cnt_ff[g] <= 8'h00;
          end else if (active && src_edge) begin
            ps_cnt_ff[g] <= ps_hit[g] ? 8'h00 : ps_cnt_ff[g] + 8'h01;
          end
        end
      end

      assign gate_fall[g] = gated && active && pin_fall[g];
      assign match[g] = count_ff[g] == period_ff[g];
    end
  endgenerate

  // Low prescaler output retimed; split high timer uses its own output directly
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      tick_sync_ff <= 1'b0;
    end else if (i_ce) begin
      tick_sync_ff <= ps_hit[0] && !ps_clr[0];
    end
  end

  // Cascade drives both halves from the low prescaler
  assign tick[0] = tick_sync_ff;
  assign tick[1] = cascade ? tick_sync_ff : (ps_hit[1] && !ps_clr[1]);

  ////////////////////////////////////////////////////////////////////////
  // Count next values

  wire [31:0] cnt32 = {count_ff[1], count_ff[0]};
  wire [31:0] per32 = {period_ff[1], period_ff[0]};
  wire match32 = cnt32 == per32;
  wire [31:0] cnt32_inc = cnt32 + 32'h1;

  logic [15:0] nxt_count [2];
  logic ev_match32;
  logic ev_gate32;

  always_comb begin
    nxt_count[0] = count_ff[0];
    nxt_count[1] = count_ff[1];
    ev_match32 = 1'b0;
    ev_gate32 = 1'b0;
    if (cascade) begin
      // Count to 32-bit period then wrap
      if (tick[0]) begin
        if (match32) begin
          nxt_count[0] = 16'h0000;
          nxt_count[1] = 16'h0000;
          ev_match32 = 1'b1;
        end else begin
          nxt_count[0] = cnt32_inc[15:0];
          nxt_count[1] = cnt32_inc[31:16];
        end
      end
      // Gate fall ends run, count kept
      ev_gate32 = gate_fall[0];
    end else begin
      if (tick[0]) begin
        nxt_count[0] = match[0] ? 16'h0000 : count_ff[0] + 16'h0001;
      end
      if (tick[1]) begin
        nxt_count[1] = match[1] ? 16'h0000 : count_ff[1] + 16'h0001;
      end
    end
    // Low write moves holding word into high count
    if (wr_low_cnt) begin
      nxt_count[0] = wdata;
      nxt_count[1] = hold_ff;
    end
    if (wr_high_cnt) begin
      nxt_count[1] = wdata;
    end
  end

  // Interrupt events: split mode keeps one flag per timer
  wire low_ev = !cascade && (tick[0] && match[0] || gate_fall[0]);
  wire high_ev = cascade ? (ev_match32 || ev_gate32) :
                 (tick[1] && match[1]);
  wire [7:0] irq_set = {high_ev, 6'h00, low_ev};
  wire [7:0] irq_clr = (wr_irq_st && lanes_ok) ? ~wdata[7:0] : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // State and register update

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      count_ff[0] <= cdt_pkg::RST_COUNT;
      count_ff[1] <= cdt_pkg::RST_COUNT;
      period_ff[0] <= cdt_pkg::RST_PERIOD;
      period_ff[1] <= cdt_pkg::RST_PERIOD;
      ctrl_ff[0] <= cdt_pkg::RST_CTRL;
      ctrl_ff[1] <= cdt_pkg::RST_CTRL;
      hold_ff <= cdt_pkg::RST_COUNT;
      irq_flag_ff <= 8'h00;
      irq_en_ff <= 8'h00;
    end else if (i_ce) begin
      count_ff[0] <= nxt_count[0];
      count_ff[1] <= nxt_count[1];
      if (rd_low_cnt) begin
        hold_ff <= count_ff[1];
      end else if (wr_hold && lanes_ok) begin
        hold_ff <= wdata;
      end
      if (wr_per_low && lanes_ok) begin
        period_ff[0] <= wdata;
      end
      if (wr_per_high && lanes_ok) begin
        period_ff[1] <= wdata;
      end
      if (wr_ctl_low && lanes_ok) begin
        ctrl_ff[0] <= wdata & cdt_pkg::LOW_CTRL_MASK;
      end
      if (wr_ctl_high && lanes_ok) begin
        ctrl_ff[1] <= wdata & cdt_pkg::HIGH_CTRL_MASK;
      end
      // Sticky flags, set wins over software clear
      irq_flag_ff <= (irq_flag_ff & ~irq_clr) | irq_set;
      if (wr_irq_en && lanes_ok) begin
        irq_en_ff <= wdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs and read mux

  logic [15:0] rd_mux;
  always_comb begin
    case (reg_idx)
      cdt_pkg::IDX_LOW_COUNT: rd_mux = count_ff[0];
      cdt_pkg::IDX_HOLD: rd_mux = hold_ff;
      cdt_pkg::IDX_HIGH_COUNT: rd_mux = count_ff[1];
      cdt_pkg::IDX_PERIOD_LOW: rd_mux = period_ff[0];
      cdt_pkg::IDX_PERIOD_HIGH: rd_mux = period_ff[1];
      cdt_pkg::IDX_LOW_CTRL: rd_mux = ctrl_ff[0];
      cdt_pkg::IDX_HIGH_CTRL: rd_mux = ctrl_ff[1];
      cdt_pkg::IDX_IRQ_STATUS: rd_mux = {8'h00, irq_flag_ff};
      cdt_pkg::IDX_IRQ_ENABLE: rd_mux = {8'h00, irq_en_ff};
      default: rd_mux = 16'h0000;
    endcase
  end

  // Cascade gates only the high flag with the high enable
  wire irq_any = cascade ?
                 (irq_flag_ff[cdt_pkg::BIT_IRQ_HIGH] &&
                  irq_en_ff[cdt_pkg::BIT_IRQ_HIGH]) :
                 |(irq_flag_ff & irq_en_ff);

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      bus_st_ff <= cdt_pkg::ST_IDLE;
      rdata_ff <= 32'h0;
      irq_ff <= 1'b0;
      adc_ff <= 1'b0;
    end else if (i_ce) begin
      irq_ff <= irq_any;
      // One-cycle converter trigger on 32-bit match
      adc_ff <= ev_match32;
      case (bus_st_ff)
        cdt_pkg::ST_IDLE: begin
          if (i_bus.read || i_bus.write) begin
            bus_st_ff <= cdt_pkg::ST_DONE;
            if (i_bus.read) begin
              rdata_ff <= {16'h0000, rd_mux};
            end
          end
        end
        cdt_pkg::ST_DONE: bus_st_ff <= cdt_pkg::ST_IDLE;
        default: bus_st_ff <= cdt_pkg::ST_IDLE;
      endcase
    end
  end

  assign o_bus.readdata = rdata_ff;
  assign o_bus.waitrequest = (bus_st_ff != cdt_pkg::ST_DONE);
  assign o_irq = irq_ff;
  assign o_adc_trigger = adc_ff;

endmodule

// ==== verification/cdt_timer_asserts.sv ====
// Checker: bus handshake and event properties of the dual timer
`timescale 1ns/100ps
module cdt_timer_asserts (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // Register bus
  input wire cdt_pkg::cdt_req_s i_bus,
  input wire cdt_pkg::cdt_rsp_s o_bus,
  // Pins and power state
  input wire logic i_low_clk_pin,
  input wire logic i_high_clk_pin,
  input wire logic i_idle,
  input wire logic i_sleep,
  // Events
  input wire logic o_irq,
  input wire logic o_adc_trigger
);
  wire req = i_bus.read || i_bus.write;
  wire rd_take = i_bus.read && o_bus.waitrequest && i_ce;
  wire [11:0] idx = i_bus.address[13:2];
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  ////////////////////////////////////////////////////////////
  a_answer_next: assert property (req && o_bus.waitrequest && i_ce
    |=> !o_bus.waitrequest) else $error("bus answer late");
  a_answer_once: assert property (!o_bus.waitrequest && i_ce
    |=> o_bus.waitrequest) else $error("bus answer too long");
  a_answer_cause: assert property (!o_bus.waitrequest |-> $past(req))
    else $error("bus answer without request");
  a_data_stands: assert property (!rd_take |=> $stable(o_bus.readdata))
    else $error("read data moved");
  a_upper_zero: assert property (o_bus.readdata[31:16] == 16'h0000)
    else $error("read data upper half set");
  a_unmapped_zero: assert property (rd_take && idx == 12'h120
    |=> o_bus.readdata == 32'h0) else $error("unmapped read not zero");
  a_ctrl_masked: assert property (rd_take && idx == cdt_pkg::IDX_LOW_CTRL
    |=> (o_bus.readdata[15:0] & ~cdt_pkg::LOW_CTRL_MASK) == 16'h0000)
    else $error("reserved control bits read set");
  a_sleep_quiet: assert property (i_sleep [*8] |-> !o_adc_trigger)
    else $error("trigger during sleep");
  a_irq_cleared: assert property ($fell(o_irq) |-> $past(i_bus.write)
    || $past(i_bus.write, 2) || $past(i_bus.write, 3))
    else $error("irq dropped without write");
  a_reset_quiet: assert property (disable iff (1'b0) !i_resetn && i_ce
    |=> o_bus.waitrequest && !o_irq && !o_adc_trigger)
    else $error("outputs active in reset");
endmodule

// ==== verification/cdt_pin_model.sv ====
// Far-side pin source: external clock pulses or gate level
`timescale 1ns/100ps
module cdt_pin_model (
  // Clock
  input wire logic i_clk,
  // Pin
  output logic o_pin
);
  initial o_pin = 1'b0;
  task automatic pulse(input int cnt, input int hi, input int lo);
    repeat (cnt) begin
      o_pin <= 1'b1;
      repeat (hi) @(posedge i_clk);
      o_pin <= 1'b0;
      repeat (lo) @(posedge i_clk);
    end
  endtask
endmodule

// ==== verification/tb_cdt_timer.sv ====
// Testbench: register, counting and event scenarios of the dual timer
`timescale 1ns/100ps
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin \
  fail_count++; $display("[ERR] %s exp %h got %h", nm, e, s); end end
module tb_cdt_timer;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_idle = 1'b0;
  logic i_sleep = 1'b0;
  logic pin;
  logic irq;
  logic trig;
  cdt_pkg::cdt_req_s req = '0;
  cdt_pkg::cdt_rsp_s rsp;
  int fail_count = 0;
  int checks_done = 0;
  int n;
  logic [15:0] v;
  always #12.5 i_clk = ~i_clk;
  cdt_timer cdt_timer_inst (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_ce(1'b1), .i_bus(req), .o_bus(rsp), .i_low_clk_pin(pin),
    .i_high_clk_pin(1'b0), .i_idle(i_idle), .i_sleep(i_sleep),
    .o_irq(irq), .o_adc_trigger(trig));
  cdt_pin_model cdt_pin_model_inst (.i_clk(i_clk), .o_pin(pin));
  ////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("Mismatches %0d in %0d checks", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [15:0] d);
    int k;
    k = 0;
    req.address <= {a, 2'b00};
    req.read <= ~wr;
    req.write <= wr;
    req.byteenable <= 4'hf;
    req.writedata <= {16'h0000, d};
    do begin
      @(posedge i_clk);
      k++;
    end while (rsp.waitrequest !== 1'b0 && k < 20);
    v = rsp.readdata[15:0];
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge i_clk);
    if (k >= 20) begin
      fail_count++;
      $display("[ERR] bus wait exp 0 got 1");
      stop_test();
    end
  endtask
  task automatic wtrig(input int lim);
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (trig !== 1'b1 && n < lim);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [11:0] ad [6];
    logic [15:0] ex [6];
    ad = '{12'h106, 12'h10a, 12'h10c, 12'h10e, 12'h110, 12'h112};
    ex = '{16'h0, 16'h0, 16'hffff, 16'hffff, 16'h0, 16'h0};
    foreach (ad[i]) begin
      bus(1'b0, ad[i], 16'h0);
      `CHK("reset value", ex[i], v)
    end
  endtask
  task automatic t_coherent;
    bus(1'b1, 12'h108, 16'h1234);
    bus(1'b1, 12'h106, 16'h5678);
    bus(1'b0, 12'h10a, 16'h0);
    `CHK("high count", 16'h1234, v)
    bus(1'b1, 12'h110, 16'h7ff7);
    bus(1'b0, 12'h110, 16'h0);
    `CHK("low control", 16'h2072, v)
    bus(1'b0, 12'h106, 16'h0);
    `CHK("low count", 16'h5678, v)
    bus(1'b1, 12'h10a, 16'h00ab);
    bus(1'b0, 12'h106, 16'h0);
    bus(1'b0, 12'h108, 16'h0);
    `CHK("holding", 16'h00ab, v)
    bus(1'b1, 12'h120, 16'hbeef);
    bus(1'b0, 12'h120, 16'h0);
    `CHK("unmapped", 16'h0000, v)
    bus(1'b1, 12'h110, 16'h0);
  endtask
  task automatic t_prescale;
    logic [15:0] dv [4];
    dv = '{16'h1, 16'h8, 16'h40, 16'h100};
    bus(1'b1, 12'h10c, 16'h0002);
    bus(1'b1, 12'h10e, 16'h0000);
    bus(1'b1, 12'h108, 16'h0000);
    bus(1'b1, 12'h106, 16'h0000);
    bus(1'b1, 12'h115, 16'h0080);
    bus(1'b1, 12'h112, 16'h8030);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 12'h110, {10'h200, i[1:0], 4'h8});
      wtrig(2000);
      wtrig(2000);
      `CHK("trigger gap", 3 * dv[i], n)
    end
    bus(1'b0, 12'h114, 16'h0);
    `CHK("irq status", 16'h0080, v)
    `CHK("irq", 1'b1, irq)
    bus(1'b1, 12'h112, 16'h0000);
    bus(1'b1, 12'h110, 16'h0000);
    bus(1'b1, 12'h114, 16'h0000);
    repeat (3) @(posedge i_clk);
    `CHK("irq cleared", 1'b0, irq)
  endtask
  task automatic t_idle;
    bus(1'b1, 12'h110, 16'ha008);
    i_idle <= 1'b1;
    repeat (6) @(posedge i_clk);
    wtrig(60);
    `CHK("idle stop", 60, n)
    i_idle <= 1'b0;
    wtrig(60);
    `CHK("idle resume", 1'b1, n < 12)
    bus(1'b1, 12'h110, 16'h8008);
    i_idle <= 1'b1;
    wtrig(60);
    wtrig(60);
    `CHK("idle run", 3, n)
    i_idle <= 1'b0;
    i_sleep <= 1'b1;
    repeat (6) @(posedge i_clk);
    wtrig(60);
    `CHK("sleep stop", 60, n)
    i_sleep <= 1'b0;
    bus(1'b1, 12'h110, 16'h0000);
  endtask
  task automatic t_extclk;
    bus(1'b1, 12'h10c, 16'h0003);
    bus(1'b1, 12'h108, 16'h0000);
    bus(1'b1, 12'h106, 16'h0000);
    bus(1'b1, 12'h110, 16'h800a);
    cdt_pin_model_inst.pulse(5, 4, 4);
    repeat (6) @(posedge i_clk);
    bus(1'b0, 12'h106, 16'h0);
    `CHK("edge count", 16'h0001, v)
    bus(1'b1, 12'h110, 16'h0000);
  endtask
  task automatic t_gated;
    logic [15:0] g;
    bus(1'b1, 12'h10c, 16'hffff);
    bus(1'b1, 12'h10e, 16'hffff);
    bus(1'b1, 12'h106, 16'h0000);
    bus(1'b1, 12'h114, 16'h0000);
    bus(1'b1, 12'h110, 16'h8048);
    cdt_pin_model_inst.pulse(1, 40, 8);
    bus(1'b0, 12'h106, 16'h0);
    g = v;
    `CHK("gated count", 1'b1, g >= 16'h26 && g <= 16'h2a)
    bus(1'b0, 12'h114, 16'h0);
    `CHK("gate flag", 16'h0080, v)
    bus(1'b0, 12'h106, 16'h0);
    `CHK("count kept", g, v)
    bus(1'b1, 12'h110, 16'h0000);
  endtask
  task automatic t_split;
    bus(1'b1, 12'h10c, 16'h0004);
    bus(1'b1, 12'h10e, 16'h0002);
    bus(1'b1, 12'h106, 16'h0000);
    bus(1'b1, 12'h10a, 16'h0000);
    bus(1'b1, 12'h114, 16'h0000);
    bus(1'b1, 12'h110, 16'h8000);
    bus(1'b1, 12'h112, 16'h8000);
    repeat (20) @(posedge i_clk);
    bus(1'b1, 12'h110, 16'h0000);
    bus(1'b1, 12'h112, 16'h0000);
    bus(1'b0, 12'h114, 16'h0);
    `CHK("split flags", 16'h0081, v)
    bus(1'b0, 12'h106, 16'h0);
    `CHK("split low wrap", 1'b1, v <= 16'h0004)
    bus(1'b0, 12'h10a, 16'h0);
    `CHK("split high wrap", 1'b1, v <= 16'h0002)
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    t_reset();
    t_coherent();
    t_prescale();
    t_idle();
    t_extclk();
    t_gated();
    t_split();
    stop_test();
  end
endmodule
bind cdt_timer cdt_timer_asserts cdt_timer_asserts_inst (.i_clk(i_clk),
  .i_resetn(i_resetn), .i_ce(i_ce), .i_bus(i_bus), .o_bus(o_bus),
  .i_low_clk_pin(i_low_clk_pin), .i_high_clk_pin(i_high_clk_pin),
  .i_idle(i_idle), .i_sleep(i_sleep), .o_irq(o_irq),
  .o_adc_trigger(o_adc_trigger));
